// ==== frsr_top.v ====
// reset control and status/config registers of a serial nor flash
// assumes a same-clock command decoder in front and an array engine behind
`timescale 1ns/100ps
`include "frsr_consts.vh"
module frsr_top
(
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  input wire CE,
  // command port from the decoder
  input wire CMD_VALID,
  input wire [7:0] CMD_OP,
  input wire [7:0] CMD_DATA1,
  input wire [7:0] CMD_DATA2,
  input wire CMD_TWO_BYTES,
  output reg CMD_TAKEN,
  output reg CMD_REFUSED,
  output reg [7:0] RD_DATA,
  output reg RD_VALID,
  // array engine
  input wire ENGINE_DONE,
  output reg ENGINE_START,
  output reg [7:0] ENGINE_OP,
  output reg ENGINE_HALT,
  output reg ENGINE_RESUME,
  output reg ENGINE_ABORT,
  // pins
  input wire HOLD_RESET_PIN_N,
  input wire WP_PIN_N,
  // status and protection view
  output wire BUSY,
  output wire WRITE_ENABLE_LATCH,
  output wire ERASE_PROGRAM_HALTED,
  output wire IN_RESET,
  output wire HOLD_ACTIVE,
  output wire QUAD_PINS_DATA,
  output wire PROT_SMALL_UNIT,
  output wire PROT_LOW_END,
  output wire [2:0] PROT_RANGE,
  output wire PROT_INVERT,
  output wire PROT_ALL_OPEN,
  output wire [2:0] OTP_LOCK
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ENGINE = 4'h2;
  localparam [3:0] ST_WRSR = 4'h4;
  localparam [3:0] ST_SWRST = 4'h8;
  // counts are integers; cut to the 8-bit timers on purpose
  localparam integer swrst_cyc_i = `FRSR_SWRST_CYC;
  localparam integer hwrst_cyc_i = `FRSR_HWRST_CYC;
  localparam integer wrsr_cyc_i = `FRSR_WRSR_CYC;
  localparam [7:0] swrst_cyc = swrst_cyc_i[7:0];
  localparam [7:0] hwrst_cyc = hwrst_cyc_i[7:0];
  localparam [7:0] wrsr_cyc = wrsr_cyc_i[7:0];

  wire [1:0] pin_s;
  wire pin_low;
  wire wp_n;
  reg [3:0] state_ff, nxt_state;
  reg [7:0] tmr_ff, nxt_tmr;
  reg [7:0] hw_cnt_ff, nxt_hw_cnt;
  // non-volatile copies
  reg [5:0] nv_sr1_ff, nxt_nv_sr1;
  reg [6:0] nv_sr2_ff, nxt_nv_sr2;
  reg nv_hrs_ff, nxt_nv_hrs;
  // volatile shadows: sr1[7:2], invert, quad
  reg [5:0] v_sr1_ff, nxt_v_sr1;
  reg v_inv_ff, nxt_v_inv;
  reg v_quad_ff, nxt_v_quad;
  // volatile status
  reg wel_ff, nxt_wel;
  reg vwe_ff, nxt_vwe;
  reg halted_ff, nxt_halted;
  reg armed_ff, nxt_armed;
  // pending status write
  reg [7:0] pend1_ff, nxt_pend1;
  reg [7:0] pend2_ff, nxt_pend2;
  reg pend_two_ff, nxt_pend_two;
  reg pend_sr3_ff, nxt_pend_sr3;
  reg nxt_taken, nxt_refused, nxt_rd_valid, nxt_start, nxt_halt, nxt_resume, nxt_abort;
  reg [7:0] nxt_rd_data, nxt_eng_op;

  wire busy = (state_ff == ST_ENGINE) || (state_ff == ST_WRSR);
  wire guard_high = nv_sr2_ff[`FRSR_SR2_GUARD_HIGH];
  wire guard_low = v_sr1_ff[`FRSR_SR1_GUARD_LOW - 2];
  // hardware reset only when selected and quad mode is off
  wire hw_low = pin_low & nv_hrs_ff & ~v_quad_ff;
  wire hw_fire = hw_low && (hw_cnt_ff == hwrst_cyc);
  // lockdown or otp when high guard set; hardware guard needs wp pin outside quad mode
  wire wr_blocked = guard_high | (guard_low & ~wp_n & ~v_quad_ff);
  wire [7:0] sr1_view = {v_sr1_ff, wel_ff, busy};
  wire [7:0] sr2_view = {halted_ff, v_inv_ff, nv_sr2_ff[5:3], 1'b0, v_quad_ff, guard_high};
  wire is_eng_op = (CMD_OP == `FRSR_OP_PP) || (CMD_OP == `FRSR_OP_SE) ||
                   (CMD_OP == `FRSR_OP_BE) || (CMD_OP == `FRSR_OP_CE);
  wire is_read = (CMD_OP == `FRSR_OP_RDSR1) || (CMD_OP == `FRSR_OP_RDSR2) || (CMD_OP == `FRSR_OP_RDSR3);

  // pins are asynchronous, synchronise before use
  frsr_sync #(.W(2)) u_sync
  (
    .clk(CORE_CLK),
    .ce(CE),
    .rst(RST),
    .d({HOLD_RESET_PIN_N, WP_PIN_N}),
    .q(pin_s)
  );
  assign pin_low = ~pin_s[1];
  assign wp_n = pin_s[0];

  // next-state logic; hardware reset is evaluated last so it wins
  always @*
  begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_hw_cnt = hw_low ? ((hw_cnt_ff == hwrst_cyc) ? hw_cnt_ff : hw_cnt_ff + 8'h01) : 8'h00;
    nxt_nv_sr1 = nv_sr1_ff;
    nxt_nv_sr2 = nv_sr2_ff;
    nxt_nv_hrs = nv_hrs_ff;
    nxt_v_sr1 = v_sr1_ff;
    nxt_v_inv = v_inv_ff;
    nxt_v_quad = v_quad_ff;
    nxt_wel = wel_ff;
    nxt_vwe = vwe_ff;
    nxt_halted = halted_ff;
    nxt_armed = armed_ff;
    nxt_pend1 = pend1_ff;
    nxt_pend2 = pend2_ff;
    nxt_pend_two = pend_two_ff;
    nxt_pend_sr3 = pend_sr3_ff;
    nxt_taken = 1'b0;
    nxt_refused = 1'b0;
    nxt_rd_valid = 1'b0;
    nxt_rd_data = RD_DATA;
    nxt_start = 1'b0;
    nxt_eng_op = ENGINE_OP;
    nxt_halt = 1'b0;
    nxt_resume = 1'b0;
    nxt_abort = 1'b0;
    // internal sequencing
    case (state_ff)
      ST_ENGINE:
      begin
        if (ENGINE_DONE)
        begin
          nxt_state = ST_IDLE;
          nxt_wel = 1'b0;
        end
      end
      ST_WRSR:
      begin
        if (tmr_ff == 8'h00)
        begin
          nxt_state = ST_IDLE;
          nxt_wel = 1'b0;
          if (pend_sr3_ff)
            nxt_nv_hrs = pend1_ff[`FRSR_SR3_HOLD_RESTART];
          else
          begin
            nxt_nv_sr1 = pend1_ff[7:2];
            nxt_v_sr1 = pend1_ff[7:2];
            if (pend_two_ff)
            begin
              // lock bits only ever accumulate ones
              nxt_nv_sr2 = {pend2_ff[6], nv_sr2_ff[5:3] | pend2_ff[5:3], 1'b0, pend2_ff[1:0]};
              nxt_v_inv = pend2_ff[6];
              nxt_v_quad = pend2_ff[1];
            end
          end
        end
        else
          nxt_tmr = tmr_ff - 8'h01;
      end
      ST_SWRST:
      begin
        if (tmr_ff == 8'h00)
          nxt_state = ST_IDLE;
        else
          nxt_tmr = tmr_ff - 8'h01;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    // command acceptance
    if (CMD_VALID)
    begin
      if (hw_low || state_ff == ST_SWRST)
        nxt_refused = 1'b1;
      else if (busy && !is_read && !(CMD_OP == `FRSR_OP_SUSP && state_ff == ST_ENGINE))
        nxt_refused = 1'b1;
      else
      begin
        nxt_taken = 1'b1;
        nxt_armed = 1'b0;
        case (CMD_OP)
          `FRSR_OP_RDSR1:
          begin
            nxt_rd_data = sr1_view;
            nxt_rd_valid = 1'b1;
          end
          `FRSR_OP_RDSR2:
          begin
            nxt_rd_data = sr2_view;
            nxt_rd_valid = 1'b1;
          end
          `FRSR_OP_RDSR3:
          begin
            nxt_rd_data = {nv_hrs_ff, 7'h00};
            nxt_rd_valid = 1'b1;
          end
          `FRSR_OP_WREN:
          begin
            nxt_wel = 1'b1;
            nxt_vwe = 1'b0;
          end
          `FRSR_OP_VWREN:
            nxt_vwe = 1'b1;
          `FRSR_OP_WRDI:
          begin
            nxt_wel = 1'b0;
            nxt_vwe = 1'b0;
          end
          `FRSR_OP_RSTEN:
            nxt_armed = 1'b1;
          `FRSR_OP_RST:
          begin
            if (armed_ff)
            begin
              nxt_state = ST_SWRST;
              nxt_tmr = swrst_cyc - 8'h01;
              nxt_v_sr1 = nv_sr1_ff;
              nxt_v_inv = nv_sr2_ff[`FRSR_SR2_INVERT];
              nxt_v_quad = nv_sr2_ff[`FRSR_SR2_QUAD];
              nxt_wel = 1'b0;
              nxt_vwe = 1'b0;
              nxt_halted = 1'b0;
            end
          end
          `FRSR_OP_WRSR, `FRSR_OP_WRSR3:
          begin
            if (wr_blocked || !(wel_ff || vwe_ff))
            begin
              nxt_taken = 1'b0;
              nxt_refused = 1'b1;
            end
            else if (vwe_ff && CMD_OP == `FRSR_OP_WRSR)
            begin
              // shadows change at once, non-volatile copies untouched
              nxt_vwe = 1'b0;
              nxt_v_sr1 = CMD_DATA1[7:2];
              if (CMD_TWO_BYTES)
              begin
                nxt_v_inv = CMD_DATA2[`FRSR_SR2_INVERT];
                nxt_v_quad = CMD_DATA2[`FRSR_SR2_QUAD];
              end
            end
            else if (wel_ff)
            begin
              nxt_vwe = 1'b0;
              nxt_state = ST_WRSR;
              nxt_tmr = wrsr_cyc - 8'h01;
              nxt_pend1 = CMD_DATA1;
              nxt_pend2 = CMD_DATA2;
              nxt_pend_two = CMD_TWO_BYTES;
              nxt_pend_sr3 = (CMD_OP == `FRSR_OP_WRSR3);
            end
            else
            begin
              // volatile enable cannot reach the select bit
              nxt_taken = 1'b0;
              nxt_refused = 1'b1;
            end
          end
          `FRSR_OP_SUSP:
          begin
            if (state_ff == ST_ENGINE && !ENGINE_DONE)
            begin
              nxt_state = ST_IDLE;
              nxt_halted = 1'b1;
              nxt_halt = 1'b1;
            end
          end
          `FRSR_OP_RESM:
          begin
            if (halted_ff)
            begin
              nxt_state = ST_ENGINE;
              nxt_halted = 1'b0;
              nxt_resume = 1'b1;
            end
          end
          default:
          begin
            if (is_eng_op)
            begin
              if (wel_ff && !halted_ff)
              begin
                nxt_state = ST_ENGINE;
                nxt_start = 1'b1;
                nxt_eng_op = CMD_OP;
                nxt_vwe = 1'b0;
              end
              else
              begin
                nxt_taken = 1'b0;
                nxt_refused = 1'b1;
              end
            end
          end
        endcase
      end
    end
    // pin reset after its minimum low time overrides everything but the non-volatile copies of a status write ending that cycle
    if (hw_fire)
    begin
      nxt_abort = (state_ff == ST_ENGINE) | halted_ff;
      nxt_state = ST_IDLE;
      nxt_tmr = 8'h00;
      nxt_v_sr1 = nv_sr1_ff;
      nxt_v_inv = nv_sr2_ff[`FRSR_SR2_INVERT];
      nxt_v_quad = nv_sr2_ff[`FRSR_SR2_QUAD];
      nxt_wel = 1'b0;
      nxt_vwe = 1'b0;
      nxt_halted = 1'b0;
      nxt_armed = 1'b0;
      nxt_start = 1'b0;
      nxt_halt = 1'b0;
      nxt_resume = 1'b0;
    end
  end

  // state registers; sync reset is power-up with factory defaults in the array bits
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state_ff <= ST_IDLE;
      tmr_ff <= 8'h00;
      hw_cnt_ff <= 8'h00;
      nv_sr1_ff <= `FRSR_NV_SR1_RST;
      nv_sr2_ff <= `FRSR_NV_SR2_RST;
      nv_hrs_ff <= `FRSR_NV_HRS_RST;
      v_sr1_ff <= `FRSR_NV_SR1_RST;
      v_inv_ff <= 1'b0;
      v_quad_ff <= 1'b0;
      wel_ff <= 1'b0;
      vwe_ff <= 1'b0;
      halted_ff <= 1'b0;
      armed_ff <= 1'b0;
      pend1_ff <= 8'h00;
      pend2_ff <= 8'h00;
      pend_two_ff <= 1'b0;
      pend_sr3_ff <= 1'b0;
      CMD_TAKEN <= 1'b0;
      CMD_REFUSED <= 1'b0;
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
      ENGINE_START <= 1'b0;
      ENGINE_OP <= 8'h00;
      ENGINE_HALT <= 1'b0;
      ENGINE_RESUME <= 1'b0;
      ENGINE_ABORT <= 1'b0;
    end
    else if (CE)
    begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      hw_cnt_ff <= nxt_hw_cnt;
      nv_sr1_ff <= nxt_nv_sr1;
      nv_sr2_ff <= nxt_nv_sr2;
      nv_hrs_ff <= nxt_nv_hrs;
      v_sr1_ff <= nxt_v_sr1;
      v_inv_ff <= nxt_v_inv;
      v_quad_ff <= nxt_v_quad;
      wel_ff <= nxt_wel;
      vwe_ff <= nxt_vwe;
      halted_ff <= nxt_halted;
      armed_ff <= nxt_armed;
      pend1_ff <= nxt_pend1;
      pend2_ff <= nxt_pend2;
      pend_two_ff <= nxt_pend_two;
      pend_sr3_ff <= nxt_pend_sr3;
      CMD_TAKEN <= nxt_taken;
      CMD_REFUSED <= nxt_refused;
      RD_DATA <= nxt_rd_data;
      RD_VALID <= nxt_rd_valid;
      ENGINE_START <= nxt_start;
      ENGINE_OP <= nxt_eng_op;
      ENGINE_HALT <= nxt_halt;
      ENGINE_RESUME <= nxt_resume;
      ENGINE_ABORT <= nxt_abort;
    end
  end

  // status and protection view; protection bits from shadow copies, lock bits and hold select from non-volatile copies
  assign BUSY = busy;
  assign WRITE_ENABLE_LATCH = wel_ff;
  assign ERASE_PROGRAM_HALTED = halted_ff;
  assign IN_RESET = hw_low | (state_ff == ST_SWRST);
  assign HOLD_ACTIVE = pin_low & ~nv_hrs_ff & ~v_quad_ff;
  assign QUAD_PINS_DATA = v_quad_ff;
  assign PROT_SMALL_UNIT = v_sr1_ff[`FRSR_SR1_SMALL_UNIT - 2];
  assign PROT_LOW_END = v_sr1_ff[`FRSR_SR1_LOW_END - 2];
  assign PROT_RANGE = v_sr1_ff[`FRSR_SR1_RANGE_HI - 2:`FRSR_SR1_RANGE_LO - 2];
  assign PROT_INVERT = v_inv_ff;
  // empty range is open unless inverted, which protects everything
  assign PROT_ALL_OPEN = (PROT_RANGE == 3'h0) & ~v_inv_ff;
  assign OTP_LOCK = nv_sr2_ff[`FRSR_SR2_LOCK_HI:`FRSR_SR2_LOCK_LO];
endmodule

// ==== frsr_consts.vh ====
// constants for the flash reset and status register block
// assumes inclusion by bare name from frsr_top.v
`ifndef FRSR_CONSTS_VH
`define FRSR_CONSTS_VH

// clock and timing, times in ns
`define FRSR_CLK_PERIOD_NS 50
`define FRSR_T_SWRST_NS 10000
`define FRSR_T_HWRST_NS 1000
`define FRSR_T_WRSR_NS 5000
`define FRSR_SWRST_CYC ((`FRSR_T_SWRST_NS + `FRSR_CLK_PERIOD_NS - 1) / `FRSR_CLK_PERIOD_NS)
`define FRSR_HWRST_CYC ((`FRSR_T_HWRST_NS + `FRSR_CLK_PERIOD_NS - 1) / `FRSR_CLK_PERIOD_NS)
`define FRSR_WRSR_CYC ((`FRSR_T_WRSR_NS + `FRSR_CLK_PERIOD_NS - 1) / `FRSR_CLK_PERIOD_NS)

// command codes
`define FRSR_OP_WREN 8'h06
`define FRSR_OP_WRDI 8'h04
`define FRSR_OP_VWREN 8'h50
`define FRSR_OP_WRSR 8'h01
`define FRSR_OP_WRSR3 8'h11
`define FRSR_OP_RDSR1 8'h05
`define FRSR_OP_RDSR2 8'h35
`define FRSR_OP_RDSR3 8'h15
`define FRSR_OP_RSTEN 8'h66
`define FRSR_OP_RST 8'h99
`define FRSR_OP_PP 8'h02
`define FRSR_OP_SE 8'h20
`define FRSR_OP_BE 8'hD8
`define FRSR_OP_CE 8'hC7
`define FRSR_OP_SUSP 8'h75
`define FRSR_OP_RESM 8'h7A

// status register one field positions
`define FRSR_SR1_GUARD_LOW 7
`define FRSR_SR1_SMALL_UNIT 6
`define FRSR_SR1_LOW_END 5
`define FRSR_SR1_RANGE_HI 4
`define FRSR_SR1_RANGE_LO 2
`define FRSR_SR1_WEL 1
`define FRSR_SR1_BUSY 0
// status register two field positions
`define FRSR_SR2_HALTED 7
`define FRSR_SR2_INVERT 6
`define FRSR_SR2_LOCK_HI 5
`define FRSR_SR2_LOCK_LO 3
`define FRSR_SR2_QUAD 1
`define FRSR_SR2_GUARD_HIGH 0
// status config three field positions
`define FRSR_SR3_HOLD_RESTART 7

// factory defaults of the non-volatile bits
`define FRSR_NV_SR1_RST 6'h00
`define FRSR_NV_SR2_RST 7'h00
`define FRSR_NV_HRS_RST 1'b0

`endif

// ==== frsr_sync.v ====
// two-flop synchroniser, one stage pair per bit
// assumes inputs are asynchronous to CORE_CLK
`timescale 1ns/100ps
module frsr_sync
#(
  parameter W = 2
)
(
  // clocking
  input wire clk,
  input wire ce,
  input wire rst,
  // data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_ff;
      reg sync_ff;
      // first stage feeds only the second; pins idle high
      always @(posedge clk)
      begin
        if (rst)
        begin
          meta_ff <= 1'b1;
          sync_ff <= 1'b1;
        end
        else if (ce)
        begin
          meta_ff <= d[i];
          sync_ff <= meta_ff;
        end
      end
      assign q[i] = sync_ff;
    end
  endgenerate
endmodule

// ==== frsr_top_checker.sv ====
// concurrent checks on the ports of the reset and status block
// assumes CE low only while idle and one clock domain; bound to frsr_top below
`timescale 1ns/100ps
module frsr_checker
(
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // command port
  input wire CMD_VALID,
  input wire [7:0] CMD_OP,
  input wire CMD_TAKEN,
  input wire CMD_REFUSED,
  // engine
  input wire ENGINE_DONE,
  input wire ENGINE_START,
  input wire ENGINE_ABORT,
  // status view
  input wire BUSY,
  input wire WRITE_ENABLE_LATCH,
  input wire IN_RESET,
  input wire HOLD_ACTIVE,
  input wire QUAD_PINS_DATA,
  input wire [2:0] PROT_RANGE,
  input wire PROT_INVERT,
  input wire PROT_ALL_OPEN
);
  reg [7:0] last_op_ff;
  reg [7:0] prev_taken_ff;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // last requested opcode and the one taken before it, for sequence rules
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      last_op_ff <= 8'h00;
      prev_taken_ff <= 8'h00;
    end
    else
    begin
      if (CMD_VALID)
        last_op_ff <= CMD_OP;
      if (CMD_TAKEN)
        prev_taken_ff <= last_op_ff;
    end
  end
  AST_SOFT_RESET_SEQ: assert property (CMD_TAKEN && last_op_ff == 8'h99 && prev_taken_ff == 8'h66 |-> IN_RESET)
    else $error("reset pair did not start the reset period");
  AST_REFUSE_IN_RESET: assert property (CMD_VALID && IN_RESET |=> CMD_REFUSED && !CMD_TAKEN)
    else $error("command taken during reset");
  AST_REFUSE_BUSY: assert property (CMD_VALID && BUSY && !(CMD_OP inside {8'h05, 8'h35, 8'h15, 8'h75})
    |=> CMD_REFUSED)
    else $error("command taken while busy");
  AST_START_NEEDS_LATCH: assert property (ENGINE_START |-> $past(WRITE_ENABLE_LATCH) && BUSY)
    else $error("engine started without latch or busy");
  AST_DONE_CLEARS: assert property (BUSY && ENGINE_DONE |=> !BUSY && !WRITE_ENABLE_LATCH)
    else $error("busy or latch left after done");
  AST_LATCH_SET_SOURCE: assert property ($rose(WRITE_ENABLE_LATCH) |-> $past(CMD_VALID) && $past(CMD_OP) == 8'h06)
    else $error("latch set by other than write enable");
  AST_QUAD_NO_HOLD: assert property (QUAD_PINS_DATA |-> !HOLD_ACTIVE)
    else $error("hold active in quad mode");
  AST_ALL_OPEN: assert property (PROT_ALL_OPEN == (PROT_RANGE == 3'h0 && !PROT_INVERT))
    else $error("open flag disagrees with range and invert");
  AST_VOLATILE_WRITE: assert property (CMD_TAKEN && last_op_ff == 8'h01 && prev_taken_ff == 8'h50
    |-> !BUSY ##1 !BUSY)
    else $error("volatile write started a busy period");
  AST_ABORT_CLEARS: assert property (ENGINE_ABORT |-> ##[0:1] (!BUSY && !WRITE_ENABLE_LATCH))
    else $error("busy or latch left after abort");
endmodule

bind frsr_top frsr_checker i_chk (.CORE_CLK, .RST, .CMD_VALID, .CMD_OP, .CMD_TAKEN, .CMD_REFUSED, .ENGINE_DONE,
  .ENGINE_START, .ENGINE_ABORT, .BUSY, .WRITE_ENABLE_LATCH, .IN_RESET, .HOLD_ACTIVE, .QUAD_PINS_DATA,
  .PROT_RANGE, .PROT_INVERT, .PROT_ALL_OPEN);

// ==== frsr_host.sv ====
// host model issuing one command at a time to the status block
// assumes the block's clock; requests change only at falling edges
`timescale 1ns/100ps
module frsr_host
(
  // clock
  input wire clk,
  // request
  output reg cmd_valid,
  output reg [7:0] cmd_op,
  output reg [7:0] cmd_data1,
  output reg [7:0] cmd_data2,
  output reg cmd_two_bytes,
  // answer
  input wire cmd_taken,
  input wire cmd_refused,
  input wire [7:0] rd_data
);
  // idle at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_data1 = 8'h00;
    cmd_data2 = 8'h00;
    cmd_two_bytes = 1'b1;
  end
  // one-cycle request; the answer is read before anything is released
  task send(input [7:0] op, input [7:0] d1, input [7:0] d2, output tk, output rf, output [7:0] rd);
  begin
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data1 = d1;
    cmd_data2 = d2;
    @(negedge clk);
    tk = cmd_taken;
    rf = cmd_refused;
    rd = rd_data;
    cmd_valid = 1'b0;
    // released lines invert so a stale byte cannot pass for a new one
    cmd_op = ~op;
    cmd_data1 = ~d1;
    cmd_data2 = ~d2;
  end
  endtask
  // selects whether a status write carries the second byte
  task set_two(input v);
  begin
    cmd_two_bytes = v;
  end
  endtask
endmodule

// ==== frsr_top_bench.sv ====
// self-checking bench for the reset and status register block
// assumes frsr_top, the host model and the bound checker are compiled with it
`timescale 1ns/100ps
module frsr_top_bench;
  typedef struct packed
  {
    logic [7:0] op;
    logic [7:0] d1;
    logic [7:0] d2;
    logic wp;
    logic tk;
    logic [7:0] rd;
  } frsr_row_t;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg hold_n = 1'b1;
  reg wp_n = 1'b1;
  reg done_p = 1'b0;
  reg ce = 1'b1;
  wire cmd_valid, cmd_two, taken, refused, rd_valid, eng_start, eng_halt, eng_resume, eng_abort;
  wire busy, write_enable_latch, halted, in_rst, hold_act, quad, p_small, p_low, p_inv, p_open;
  wire [7:0] cmd_op, cmd_d1, cmd_d2, rd_data, eng_op;
  wire [2:0] p_range, otp;
  frsr_row_t rows [0:22];
  integer i, n, cycles = 0, num_errors = 0, n_tests = 0;
  reg tk, rf, seen;
  reg [7:0] rd;
  // free-running clock, 50 ns period
  always #25 core_clk = ~core_clk;
  frsr_top i_dut (.CORE_CLK(core_clk), .RST(rst), .CE(ce), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_DATA1(cmd_d1), .CMD_DATA2(cmd_d2), .CMD_TWO_BYTES(cmd_two), .CMD_TAKEN(taken), .CMD_REFUSED(refused),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .ENGINE_DONE(done_p), .ENGINE_START(eng_start), .ENGINE_OP(eng_op),
    .ENGINE_HALT(eng_halt), .ENGINE_RESUME(eng_resume), .ENGINE_ABORT(eng_abort), .HOLD_RESET_PIN_N(hold_n),
    .WP_PIN_N(wp_n), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .ERASE_PROGRAM_HALTED(halted), .IN_RESET(in_rst),
    .HOLD_ACTIVE(hold_act), .QUAD_PINS_DATA(quad), .PROT_SMALL_UNIT(p_small), .PROT_LOW_END(p_low),
    .PROT_RANGE(p_range), .PROT_INVERT(p_inv), .PROT_ALL_OPEN(p_open), .OTP_LOCK(otp));
  frsr_host i_host (.clk(core_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data1(cmd_d1),
    .cmd_data2(cmd_d2), .cmd_two_bytes(cmd_two), .cmd_taken(taken), .cmd_refused(refused), .rd_data(rd_data));
  // hang guard, far above the thousand or so cycles the run needs
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 10000)
    begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end
  task check(input string what, input logic [7:0] seen_v, input logic [7:0] exp_v);
  begin
    n_tests = n_tests + 1;
    if (seen_v !== exp_v)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp_v, seen_v);
    end
  end
  endtask
  task cmd(input [7:0] op, input [7:0] d1, input [7:0] d2);
    i_host.send(op, d1, d2, tk, rf, rd);
  endtask
  // bounded wait for status writes and reset periods to finish
  task wait_idle;
  begin
    n = 0;
    while ((busy === 1'b1 || in_rst === 1'b1) && n < 400)
    begin
      @(negedge core_clk);
      n = n + 1;
    end
  end
  endtask
  task pulse_done;
  begin
    @(negedge core_clk);
    done_p = 1'b1;
    @(negedge core_clk);
    done_p = 1'b0;
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  initial
  begin
    // op, data1, data2, write-protect pin, taken, read value
    rows = '{'{8'h05, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00}, '{8'h35, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00},
      '{8'h15, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00}, '{8'h01, 8'hFC, 8'h78, 1'b1, 1'b0, 8'h00},
      '{8'h06, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00}, '{8'h05, 8'h00, 8'h00, 1'b1, 1'b1, 8'h02},
      '{8'h01, 8'h7C, 8'h38, 1'b1, 1'b1, 8'h00}, '{8'h05, 8'h00, 8'h00, 1'b1, 1'b1, 8'h7C},
      '{8'h35, 8'h00, 8'h00, 1'b1, 1'b1, 8'h38}, '{8'h06, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00},
      '{8'h01, 8'h7C, 8'h00, 1'b1, 1'b1, 8'h00}, '{8'h35, 8'h00, 8'h00, 1'b1, 1'b1, 8'h38},
      '{8'h50, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00}, '{8'h01, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00},
      '{8'h05, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00}, '{8'h35, 8'h00, 8'h00, 1'b1, 1'b1, 8'h38},
      '{8'h66, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00}, '{8'h99, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00},
      '{8'h05, 8'h00, 8'h00, 1'b1, 1'b1, 8'h7C}, '{8'h06, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00},
      '{8'h01, 8'hFC, 8'h38, 1'b1, 1'b1, 8'h00}, '{8'h06, 8'h00, 8'h00, 1'b0, 1'b1, 8'h00},
      '{8'h01, 8'h7C, 8'h38, 1'b0, 1'b0, 8'h00}};
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    check("open after reset", 8'(p_open), 8'h01);
    // frozen clock enable: a write enable must not land
    ce = 1'b0;
    cmd(8'h06, 8'h00, 8'h00);
    ce = 1'b1;
    check("frozen", {6'h00, tk, write_enable_latch}, 8'h00);
    $display("clock enable done");
    for (i = 0; i < 23; i = i + 1)
    begin
      wp_n = rows[i].wp;
      repeat (3) @(negedge core_clk);
      cmd(rows[i].op, rows[i].d1, rows[i].d2);
      check("taken", 8'(tk), 8'(rows[i].tk));
      if (rows[i].op == 8'h05 || rows[i].op == 8'h35 || rows[i].op == 8'h15)
      begin
        check("read", rd, rows[i].rd);
        check("read valid", 8'(rd_valid), 8'h01);
      end
      wait_idle;
    end
    check("small unit", 8'(p_small), 8'h01);
    check("low end", 8'(p_low), 8'h01);
    check("range", 8'(p_range), 8'h07);
    check("open", 8'(p_open), 8'h00);
    $display("table and protection view done");
    // software reset: a status read refused inside the period, then its length
    wp_n = 1'b1;
    cmd(8'h66, 8'h00, 8'h00);
    cmd(8'h99, 8'h00, 8'h00);
    cmd(8'h05, 8'h00, 8'h00);
    check("refused in reset", 8'(rf), 8'h01);
    wait_idle;
    check("reset length", n[7:0], 8'hC6);
    $display("software reset done");
    // program: latch needed, busy refusals, done clears latch
    cmd(8'h06, 8'h00, 8'h00);
    cmd(8'h04, 8'h00, 8'h00);
    check("disable", 8'(write_enable_latch), 8'h00);
    cmd(8'h02, 8'h00, 8'h00);
    check("no latch start", 8'(rf), 8'h01);
    cmd(8'h06, 8'h00, 8'h00);
    cmd(8'h02, 8'h00, 8'h00);
    check("start", {6'h00, eng_start, busy}, 8'h03);
    check("start op", eng_op, 8'h02);
    cmd(8'h06, 8'h00, 8'h00);
    check("busy refusal", 8'(rf), 8'h01);
    cmd(8'h05, 8'h00, 8'h00);
    check("status while busy", rd, 8'hFF);
    pulse_done;
    check("after done", {6'h00, write_enable_latch, busy}, 8'h00);
    // suspend and resume of an erase
    cmd(8'h06, 8'h00, 8'h00);
    cmd(8'h20, 8'h00, 8'h00);
    cmd(8'h75, 8'h00, 8'h00);
    check("halted", {6'h00, halted, eng_halt}, 8'h03);
    cmd(8'h7A, 8'h00, 8'h00);
    check("resumed", {6'h00, halted, eng_resume}, 8'h01);
    pulse_done;
    check("erase end", 8'(busy), 8'h00);
    $display("program and suspend done");
    // hold function, then quad mode takes the pin away
    hold_n = 1'b0;
    repeat (3) @(negedge core_clk);
    check("hold", {6'h00, hold_act, in_rst}, 8'h02);
    cmd(8'h50, 8'h00, 8'h00);
    cmd(8'h01, 8'hFC, 8'h7A);
    check("quad", {5'h00, quad, hold_act, in_rst}, 8'h04);
    check("invert", 8'(p_inv), 8'h01);
    // one-byte volatile write leaves the second register's shadows alone
    i_host.set_two(1'b0);
    cmd(8'h50, 8'h00, 8'h00);
    cmd(8'h01, 8'hFC, 8'h00);
    check("one byte", {6'h00, quad, p_inv}, 8'h03);
    i_host.set_two(1'b1);
    cmd(8'h50, 8'h00, 8'h00);
    cmd(8'h01, 8'hFC, 8'h38);
    hold_n = 1'b1;
    // pin reset during an erase, write-protect low as well
    cmd(8'h06, 8'h00, 8'h00);
    cmd(8'h11, 8'h80, 8'h00);
    wait_idle;
    cmd(8'h15, 8'h00, 8'h00);
    check("select bit", rd, 8'h80);
    cmd(8'h06, 8'h00, 8'h00);
    cmd(8'hD8, 8'h00, 8'h00);
    wp_n = 1'b0;
    hold_n = 1'b0;
    repeat (3) @(negedge core_clk);
    check("pin reset", 8'(in_rst), 8'h01);
    cmd(8'h05, 8'h00, 8'h00);
    check("refused low", 8'(rf), 8'h01);
    seen = 1'b0;
    repeat (40)
    begin
      @(negedge core_clk);
      if (eng_abort === 1'b1)
        seen = 1'b1;
    end
    hold_n = 1'b1;
    wp_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check("abort", 8'(seen), 8'h01);
    check("after pin reset", {5'h00, busy, write_enable_latch, in_rst}, 8'h00);
    cmd(8'h35, 8'h00, 8'h00);
    check("kept bits", rd, 8'h38);
    check("locks", 8'(otp), 8'h07);
    $display("hold and pin reset done");
    // power-up again: factory defaults return
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    check("power-up", {3'h0, otp, busy, write_enable_latch}, 8'h00);
    $display("power-up done");
    print_verdict;
  end
endmodule
